// *** hw/event_flag_defs.vh ***
// What this block does
// - Set-register bits 0..5 set the six channel edge flags; zeros do nothing.
// - Set-register bits 6..9 set the four timer match flags in order.
// - Set-register bit 10 sets trap flag and trap state together.
// - Set-register bit 11 starts a Hall compare, setting no flag directly.
// - Set-register bits 12..15 set correct hall, wrong hall, idle, transfer flags.
// - Software-set flags raise the same interrupt event as hardware sets.
// - Clear-register ones clear matching flags; zeros keep them; reads zero.
// - Clear-register bits 0..9 map like set-register bits 0..9.
// - Clear bit 10 clears trap flag only, ignored while trap pin active.
// - Clear-register bit 11 is reserved, reads zero, software writes zero.
// - Clear-register bits 12..15 clear hall, wrong hall, idle, transfer flags.
// - Clear register at 0C, set register at 4C, both 16 bits, reset zero.
// - Hardware sets trap flag when pin enable is one and trap input low.
// - Idle flag sets with wrong hall flag and holds until cleared.
//
// Purpose: Constants for the event flag set/clear register block.
// Assumes: Byte addresses on a register port with 8-bit address and 16-bit data.
// Notes: Status and control offsets are placed in free address space.
`ifndef EVENT_FLAG_DEFS_VH
`define EVENT_FLAG_DEFS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_W 8
`define DATA_W 16
`define OFS_CLEAR 8'h0C
`define OFS_SET 8'h4C
`define OFS_STATUS 8'h10
`define OFS_CTRL 8'h14
`define FLAGS_RESET 16'h0000
`define CTRL_RESET 1'h0
`define READ_ZERO 16'h0000

// ----------------------------------------------------------------
// Bit positions in the status, set, clear and control registers
// ----------------------------------------------------------------
`define BIT_CH0_RISE 0
`define BIT_CH0_FALL 1
`define BIT_CH1_RISE 2
`define BIT_CH1_FALL 3
`define BIT_CH2_RISE 4
`define BIT_CH2_FALL 5
`define BIT_TIMER_A_ONE 6
`define BIT_TIMER_A_PERIOD 7
`define BIT_TIMER_B_COMPARE 8
`define BIT_TIMER_B_PERIOD 9
`define BIT_TRAP_FLAG 10
`define BIT_CLEAR_RESERVED 11
`define BIT_TRAP_STATE 11
`define BIT_HALL_TRIG 11
`define BIT_CORRECT_HALL 12
`define BIT_WRONG_HALL 13
`define BIT_IDLE 14
`define BIT_XFER 15
`define BIT_TRAP_PIN_EN 0

// Clear-register bits that software may act on (bit 11 reserved)
`define CLEAR_MASK 16'hF7FF
// Status bits that hardware event inputs may set
`define HW_SET_MASK 16'hF3FF

`endif

// *** hw/pin_sync3.v ***
// Purpose: Bring an asynchronous pin into the clock domain.
// Assumes: Pin may change at any time relative to clock.
// Notes: Output follows only when the second and third stages agree.
`timescale 1ns/1ps
module pin_sync3 #(
    parameter RESET_LEVEL = 1'b1
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Pin and filtered level
    input wire pin,
    output reg level_q
);
    reg meta_q;
    reg s2_q;
    reg s3_q;

    // Only s2 reads meta_q; the agreement check looks at s2 and s3
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= RESET_LEVEL;
            s2_q <= RESET_LEVEL;
            s3_q <= RESET_LEVEL;
            level_q <= RESET_LEVEL;
        end else begin
            meta_q <= pin;
            s2_q <= meta_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end
endmodule // pin_sync3

// *** hw/event_flag_set_clear_regs.v ***
// Purpose: Event status flags with software set and clear registers.
// Assumes: Hardware event inputs are one-cycle pulses on clock.
// Notes: Interrupt enables and line selection live outside this block.
`timescale 1ns/1ps
`include "event_flag_defs.vh"
module event_flag_set_clear_regs #(
    parameter ADDR_W = `ADDR_W,
    parameter DATA_W = `DATA_W
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Register port
    input wire [ADDR_W-1:0] addr,
    input wire [DATA_W-1:0] wdata,
    input wire wr,
    input wire rd,
    output reg [DATA_W-1:0] rdata,
    // Hardware flag sources
    input wire [DATA_W-1:0] hw_event,
    input wire trap_input_n,
    input wire trap_state_release,
    // Flag state and events
    output reg [DATA_W-1:0] event_status_reg,
    output reg [DATA_W-1:0] flag_set_event,
    output reg sw_hall_compare,
    output wire trap_pin_enable
);
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function hit;
        input [ADDR_W-1:0] a;
        input [ADDR_W-1:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // Set-register bit n, other than Hall trigger bit 11, sets the status flag at its own position
    function set_lands;
        input integer n;
        begin
            case (n)
                // Channel 0
                `BIT_CH0_RISE: set_lands = 1'b1;
                `BIT_CH0_FALL: set_lands = 1'b1;

                // Channel 1
                `BIT_CH1_RISE: set_lands = 1'b1;
                `BIT_CH1_FALL: set_lands = 1'b1;

                // Channel 2
                `BIT_CH2_RISE: set_lands = 1'b1;
                `BIT_CH2_FALL: set_lands = 1'b1;

                // Timer A
                `BIT_TIMER_A_ONE: set_lands = 1'b1;
                `BIT_TIMER_A_PERIOD: set_lands = 1'b1;

                // Timer B
                `BIT_TIMER_B_COMPARE: set_lands = 1'b1;
                `BIT_TIMER_B_PERIOD: set_lands = 1'b1;

                // Trap
                `BIT_TRAP_FLAG: set_lands = 1'b1;

                // Hall trigger sets no flag
                `BIT_HALL_TRIG: set_lands = 1'b0;

                // Hall outcomes
                `BIT_CORRECT_HALL: set_lands = 1'b1;
                `BIT_WRONG_HALL: set_lands = 1'b1;

                // Idle and transfer
                `BIT_IDLE: set_lands = 1'b1;
                `BIT_XFER: set_lands = 1'b1;
                default: set_lands = 1'b0;
            endcase
        end
    endfunction

    // Clear-register bit n, other than reserved bit 11, clears the flag at its own position
    function clear_lands;
        input integer n;
        begin
            case (n)
                // Channel 0
                `BIT_CH0_RISE: clear_lands = 1'b1;
                `BIT_CH0_FALL: clear_lands = 1'b1;

                // Channel 1
                `BIT_CH1_RISE: clear_lands = 1'b1;
                `BIT_CH1_FALL: clear_lands = 1'b1;

                // Channel 2
                `BIT_CH2_RISE: clear_lands = 1'b1;
                `BIT_CH2_FALL: clear_lands = 1'b1;

                // Timer A
                `BIT_TIMER_A_ONE: clear_lands = 1'b1;
                `BIT_TIMER_A_PERIOD: clear_lands = 1'b1;

                // Timer B
                `BIT_TIMER_B_COMPARE: clear_lands = 1'b1;
                `BIT_TIMER_B_PERIOD: clear_lands = 1'b1;

                // Trap flag only, never the trap state
                `BIT_TRAP_FLAG: clear_lands = 1'b1;

                // Reserved
                `BIT_CLEAR_RESERVED: clear_lands = 1'b0;

                // Hall outcomes
                `BIT_CORRECT_HALL: clear_lands = 1'b1;
                `BIT_WRONG_HALL: clear_lands = 1'b1;

                // Idle and transfer
                `BIT_IDLE: clear_lands = 1'b1;
                `BIT_XFER: clear_lands = 1'b1;
                default: clear_lands = 1'b0;
            endcase
        end
    endfunction

    // Status bits that a hardware event pulse may set; the trap pair follows the pin
    function hw_lands;
        input integer n;
        begin
            case (n)
                // Channel 0
                `BIT_CH0_RISE: hw_lands = 1'b1;
                `BIT_CH0_FALL: hw_lands = 1'b1;

                // Channel 1
                `BIT_CH1_RISE: hw_lands = 1'b1;
                `BIT_CH1_FALL: hw_lands = 1'b1;

                // Channel 2
                `BIT_CH2_RISE: hw_lands = 1'b1;
                `BIT_CH2_FALL: hw_lands = 1'b1;

                // Timer A
                `BIT_TIMER_A_ONE: hw_lands = 1'b1;
                `BIT_TIMER_A_PERIOD: hw_lands = 1'b1;

                // Timer B
                `BIT_TIMER_B_COMPARE: hw_lands = 1'b1;
                `BIT_TIMER_B_PERIOD: hw_lands = 1'b1;

                // Trap flag
                `BIT_TRAP_FLAG: hw_lands = 1'b0;

                // Trap state
                `BIT_TRAP_STATE: hw_lands = 1'b0;

                // Hall outcomes
                `BIT_CORRECT_HALL: hw_lands = 1'b1;
                `BIT_WRONG_HALL: hw_lands = 1'b1;

                // Idle and transfer
                `BIT_IDLE: hw_lands = 1'b1;
                `BIT_XFER: hw_lands = 1'b1;
                default: hw_lands = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    wire wr_set = wr && hit(addr, `OFS_SET);
    wire wr_clear = wr && hit(addr, `OFS_CLEAR);
    wire wr_ctrl = wr && hit(addr, `OFS_CTRL);

    // ------------------------------------------------------------
    // Control register and trap pin
    // ------------------------------------------------------------
    reg trap_pin_enable_q;
    wire trap_level;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            trap_pin_enable_q <= `CTRL_RESET;
        end else if (wr_ctrl) begin
            trap_pin_enable_q <= wdata[`BIT_TRAP_PIN_EN];
        end
    end
    assign trap_pin_enable = trap_pin_enable_q;

    pin_sync3 #(
        .RESET_LEVEL(1'b1)
    ) u_trap_sync (
        .clock(clock),
        .rst(rst),
        .pin(trap_input_n),
        .level_q(trap_level)
    );

    // Trap condition as seen after the filter
    wire trap_active = trap_pin_enable_q && !trap_level;

    // ------------------------------------------------------------
    // Software set requests
    // ------------------------------------------------------------
    genvar b;
    wire [DATA_W-1:0] sw_set;

    generate
        for (b = 0; b < DATA_W; b = b + 1) begin : g_set
            assign sw_set[b] = wr_set && wdata[b] && set_lands(b);
        end
    endgenerate

    // ------------------------------------------------------------
    // Software clear requests
    // ------------------------------------------------------------
    wire [DATA_W-1:0] sw_clr;

    generate
        for (b = 0; b < DATA_W; b = b + 1) begin : g_clr
            assign sw_clr[b] = wr_clear && wdata[b] && clear_lands(b);
        end
    endgenerate

    // ------------------------------------------------------------
    // Hardware set requests
    // ------------------------------------------------------------
    wire [DATA_W-1:0] hw_set;

    generate
        for (b = 0; b < DATA_W; b = b + 1) begin : g_hw
            assign hw_set[b] = hw_event[b] && hw_lands(b);
        end
    endgenerate

    // ------------------------------------------------------------
    // Trap flag and trap state
    // ------------------------------------------------------------
    reg trap_set;
    reg trap_clear;
    reg state_set;
    reg state_clear;

    // Pin and software may both set; a clear is refused while the pin holds
    always @* begin
        trap_set = sw_set[`BIT_TRAP_FLAG] || trap_active;
        if (trap_active) begin
            trap_clear = 1'b0;
        end else begin
            trap_clear = sw_clr[`BIT_TRAP_FLAG];
        end
    end

    // Trap state is released by the trap mode logic outside, never by software
    always @* begin
        state_set = trap_set;
        state_clear = trap_state_release;
    end

    // ------------------------------------------------------------
    // Hall outcome flags and idle
    // ------------------------------------------------------------
    reg wrong_hall_set;
    reg idle_set;

    // Idle follows a wrong Hall outcome from either source
    always @* begin
        wrong_hall_set = sw_set[`BIT_WRONG_HALL] || hw_set[`BIT_WRONG_HALL];
        idle_set = sw_set[`BIT_IDLE] || hw_set[`BIT_IDLE] || wrong_hall_set;
    end

    // ------------------------------------------------------------
    // Software Hall compare trigger
    // ------------------------------------------------------------
    // The trigger bit sets no flag; it only starts a compare outside
    wire hall_trigger = wr_set && wdata[`BIT_HALL_TRIG];

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            sw_hall_compare <= 1'b0;
        end else begin
            sw_hall_compare <= hall_trigger;
        end
    end

    // ------------------------------------------------------------
    // Per-flag set and clear vectors
    // ------------------------------------------------------------
    wire [DATA_W-1:0] set_d;
    wire [DATA_W-1:0] clr_d;

    // The trap pair and idle take their requests from the logic above
    generate
        for (b = 0; b < DATA_W; b = b + 1) begin : g_merge
            if (b == `BIT_TRAP_FLAG) begin : g_trap
                assign set_d[b] = trap_set;
                assign clr_d[b] = trap_clear;
            end else if (b == `BIT_TRAP_STATE) begin : g_state
                assign set_d[b] = state_set;
                assign clr_d[b] = state_clear;
            end else if (b == `BIT_IDLE) begin : g_idle
                assign set_d[b] = idle_set;
                assign clr_d[b] = sw_clr[b];
            end else begin : g_plain
                assign set_d[b] = sw_set[b] || hw_set[b];
                assign clr_d[b] = sw_clr[b];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Flag storage
    // ------------------------------------------------------------
    // Set is tested first so an event is never lost to a clear
    genvar i;
    generate
        for (i = 0; i < DATA_W; i = i + 1) begin : g_flag
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    event_status_reg[i] <= 1'b0;
                end else if (set_d[i]) begin
                    event_status_reg[i] <= 1'b1;
                end else if (clr_d[i]) begin
                    event_status_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Event pulses toward the interrupt enable logic
    // ------------------------------------------------------------
    // Software and hardware sets share one pulse so enables treat them alike
    generate
        for (b = 0; b < DATA_W; b = b + 1) begin : g_pulse
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    flag_set_event[b] <= 1'b0;
                end else begin
                    flag_set_event[b] <= set_d[b];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    reg [DATA_W-1:0] read_mux;

    // Set and clear registers are write-only and read as zero
    always @* begin
        case (addr)
            `OFS_STATUS: read_mux = event_status_reg;
            `OFS_CTRL: read_mux = {{(DATA_W-1){1'b0}}, trap_pin_enable_q};
            `OFS_CLEAR: read_mux = `READ_ZERO;
            `OFS_SET: read_mux = `READ_ZERO;
            default: read_mux = `READ_ZERO;
        endcase
    end

    // Data stand for the one cycle after the strobe, zero otherwise
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= `READ_ZERO;
        end else if (rd) begin
            rdata <= read_mux;
        end else begin
            rdata <= `READ_ZERO;
        end
    end
endmodule // event_flag_set_clear_regs

// *** verif/event_flag_checker_properties.sv ***
// Purpose: Port assertions for the event flag set/clear register block.
// Assumes: Default widths (8-bit address, 16-bit data).
// Notes: Clear checks skip cycles with hardware sets, which win by design.
`timescale 1ns/1ps
module event_flag_checker (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Register port
    input wire [7:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    input wire [15:0] rdata,
    // Flag sources and state
    input wire [15:0] hw_event,
    input wire trap_input_n,
    input wire [15:0] event_status_reg,
    input wire [15:0] flag_set_event,
    input wire sw_hall_compare,
    input wire trap_pin_enable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence set_wr; wr && addr == 8'h4C; endsequence
    sequence clr_wr; wr && addr == 8'h0C && hw_event == 16'h0000; endsequence
    set_flags_a: assert property (set_wr |=>
        (~event_status_reg & $past(wdata) & 16'hF7FF) == 16'h0000) else $error("Set lost");
    trap_pair_a: assert property (set_wr ##0 wdata[10] |=>
        event_status_reg[11:10] == 2'b11) else $error("Trap pair not set");
    hall_trig_a: assert property (set_wr ##0 wdata[11] |=> sw_hall_compare)
        else $error("No hall compare pulse");
    set_event_a: assert property (set_wr |=>
        (~flag_set_event & $past(wdata) & 16'hF7FF) == 16'h0000) else $error("No set event");
    clear_ones_a: assert property (clr_wr |=>
        (event_status_reg & $past(wdata) & 16'hF3FF) == 16'h0000) else $error("Clear failed");
    clear_zeros_a: assert property (clr_wr |=>
        ((event_status_reg ^ $past(event_status_reg)) & ~$past(wdata) & 16'hF3FF) == 16'h0000)
        else $error("Zero bit changed a flag");
    pin_trap_a: assert property ((trap_pin_enable && !trap_input_n) [*6] |=>
        event_status_reg[10]) else $error("Trap flag dropped");
    idle_follow_a: assert property (((hw_event[13]) or (set_wr ##0 wdata[13])) |=>
        event_status_reg[14]) else $error("Idle not set");
    hw_wins_a: assert property ((hw_event & 16'hF3FF) != 16'h0000 |=>
        (~event_status_reg & $past(hw_event) & 16'hF3FF) == 16'h0000) else $error("Hw set lost");
    read_zero_a: assert property (rd && (addr == 8'h0C || addr == 8'h4C) |=>
        rdata == 16'h0000) else $error("Write-only reg read nonzero");
endmodule // event_flag_checker

bind event_flag_set_clear_regs event_flag_checker chk_u (.clock, .rst, .addr, .wdata, .wr,
    .rd, .rdata, .hw_event, .trap_input_n, .event_status_reg, .flag_set_event,
    .sw_hall_compare, .trap_pin_enable);

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the event flag set/clear registers.
// Assumes: Status at 0x10, control at 0x14, reads one cycle after rd.
// Notes: Trap state only leaves through trap_state_release pulses.
`timescale 1ns/1ps
module tb;
    reg clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    reg trap_input_n = 1'b1, trap_state_release = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [15:0] wdata = 16'h0000, hw_event = 16'h0000, exp, bit_v;
    wire [15:0] rdata, event_status_reg, flag_set_event;
    wire sw_hall_compare, trap_pin_enable;
    integer fail_count = 0, tests_run = 0, cycles = 0, i;
    event_flag_set_clear_regs dut_u (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata, .hw_event,
        .trap_input_n, .trap_state_release, .event_status_reg, .flag_set_event,
        .sw_hall_compare, .trap_pin_enable);
    initial forever #5 clock = ~clock;
    task chk(input [15:0] got, input [15:0] want);
        begin
            tests_run = tests_run + 1;
            if (got !== want) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
            end
        end
    endtask
    task wr_reg(input [7:0] a, input [15:0] d);
        begin
            @(posedge clock) {addr, wdata, wr} <= {a, d, 1'b1};
            @(posedge clock) wr <= 1'b0;
            #1;
        end
    endtask
    task rd_chk(input [7:0] a, input [15:0] want);
        begin
            @(posedge clock) {addr, rd} <= {a, 1'b1};
            @(posedge clock) rd <= 1'b0;
            #1 chk(rdata, want);
        end
    endtask
    task release_state;
        begin
            @(posedge clock) trap_state_release <= 1'b1;
            @(posedge clock) trap_state_release <= 1'b0;
            #1;
        end
    endtask
    task give_verdict;
        begin
            if (fail_count == 0 && tests_run > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    // Hang guard: the whole sequence needs well under 1000 cycles
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            fail_count = fail_count + 1;
            give_verdict;
        end
    end
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        #1 chk(event_status_reg, 16'h0000);
        for (i = 0; i < 16; i = i + 1) if (i != 11) begin
            bit_v = 16'h0001 << i;
            exp = bit_v | (i == 10 ? 16'h0800 : 16'h0000) | (i == 13 ? 16'h4000 : 16'h0000);
            wr_reg(8'h4C, bit_v);
            chk(event_status_reg, exp);
            chk(flag_set_event & bit_v, bit_v);
            wr_reg(8'h0C, bit_v);
            chk(event_status_reg, exp & ~bit_v);
            wr_reg(8'h0C, 16'hF7FF);
            release_state;
        end
        wr_reg(8'h4C, 16'h0800);
        chk({15'h0000, sw_hall_compare}, 16'h0001);
        chk(event_status_reg, 16'h0000);
        wr_reg(8'h4C, 16'hFFFF);
        wr_reg(8'h0C, 16'h0800);
        wr_reg(8'h0C, 16'h0000);
        chk(event_status_reg, 16'hFFFF);
        rd_chk(8'h10, 16'hFFFF);
        rd_chk(8'h0C, 16'h0000);
        rd_chk(8'h4C, 16'h0000);
        wr_reg(8'h0C, 16'hFFFF);
        release_state;
        wr_reg(8'h20, 16'hFFFF);
        chk(event_status_reg, 16'h0000);
        rd_chk(8'h20, 16'h0000);
        // Set and clear of the same flag in one cycle
        wr_reg(8'h4C, 16'h0008);
        @(posedge clock) {addr, wdata, wr, hw_event} <= {8'h0C, 16'h0008, 1'b1, 16'h0008};
        @(posedge clock) {wr, hw_event} <= {1'b0, 16'h0000};
        #1 chk(event_status_reg, 16'h0008);
        wr_reg(8'h0C, 16'h0008);
        // Trap pin held active blocks the software clear
        wr_reg(8'h14, 16'h0001);
        chk({15'h0000, trap_pin_enable}, 16'h0001);
        rd_chk(8'h14, 16'h0001);
        @(posedge clock) trap_input_n <= 1'b0;
        repeat (8) @(posedge clock);
        wr_reg(8'h0C, 16'h0400);
        chk(event_status_reg, 16'h0C00);
        @(posedge clock) trap_input_n <= 1'b1;
        repeat (8) @(posedge clock);
        wr_reg(8'h0C, 16'h0400);
        release_state;
        chk(event_status_reg, 16'h0000);
        give_verdict;
    end
endmodule // tb
